// File: hw/sbl_defs.svh
// Constants of the serial boot loader port: widths, counts, config values and timing.
//
// Summary of operation
// - Receive shift word fixed at 32 bits.
// - Narrow sources pack into 32-bit words LSB first.
// - Slave receive DMA starts at 384 words.
// - Slave config: enabled, slave, LSB, length 10, DMA.
// - Slave boot: data out off, clock low, phase set.
// - Master boot: drive clock, flag-0 select low.
// - Master sends read opcode 03, zero address.
// - Command is one 32-bit word, LSB first.
// - Word received during command is discarded.
// - First stream bit at cycle 32, keep clocking.
// - Master behaves the same for every slave type.
// - Boot mode taken from config pins at reset.
`ifndef SBL_DEFS_SVH
`define SBL_DEFS_SVH

// -----------------------------------------------------------------------------
// Word and count sizes
// -----------------------------------------------------------------------------
`define SBL_WORD_BITS 32
`define SBL_DMA_WORDS 9'h180
`define SBL_LAST_BIT 5'h1F

// -----------------------------------------------------------------------------
// Control field values
// -----------------------------------------------------------------------------
`define SBL_WL_32 2'h2
`define SBL_CMD_WORD 32'h000000C0

// -----------------------------------------------------------------------------
// Timing: serial clock half period in ns, converted to clk cycles (20 MHz)
// -----------------------------------------------------------------------------
`define SBL_CLK_MHZ 20
`define SBL_SCLK_HALF_NS 200
`define SBL_SCLK_HALF_CYC (`SBL_SCLK_HALF_NS * `SBL_CLK_MHZ / 1000)

`endif

// File: hw/sbl_pkg.sv
// Types shared by the serial boot loader port.
package sbl_pkg;
  // Boot source decoded from the configuration pins.
  typedef enum logic [1:0] {
    SBL_MODE_SLAVE = 2'h0,
    SBL_MODE_MASTER = 2'h1,
    SBL_MODE_PARALLEL = 2'h2,
    SBL_MODE_NONE = 2'h3
  } sbl_mode_e;

  // Boot sequencer states, Gray coded along idle, command, data, done.
  typedef enum logic [1:0] {
    SBL_ST_IDLE = 2'h0,
    SBL_ST_CMD = 2'h1,
    SBL_ST_DATA = 2'h3,
    SBL_ST_DONE = 2'h2
  } sbl_state_e;
endpackage

// File: hw/sbl_sync2.sv
// Two-stage level synchroniser of configurable width.
`timescale 1ns/100ps
module sbl_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Asynchronous level in, synchronised level out.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff; // First stage, read only by the second stage.

  // Two flops in series; only the second stage is visible outside.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // sbl_sync2

// File: hw/sbl_link.sv
// Slave-mode receive shifter running on the host's serial clock.
`timescale 1ns/100ps
`include "sbl_defs.svh"
module sbl_link (
  // Link clock from the host and system reset.
  input wire logic serial_clock_in,
  input wire logic reset_n,
  // Serial pins as seen in slave role.
  input wire logic slave_select_in,
  input wire logic mosi_in,
  // Completed word and its event toggle for the system domain.
  output logic [31:0] word_ff,
  output logic word_tgl_ff
);
  logic [31:0] sr_ff; // Receive shift register.
  logic [4:0] bit_cnt_ff; // Bits taken in the current word.
  logic sel_rst_n; // Count reset: system reset or select released.
  logic [31:0] nxt_sr; // Shift register after this bit.

  // A high select holds the counter cleared, so clock edges outside a frame
  // are ignored and each falling select restarts at bit zero.
  assign sel_rst_n = reset_n & ~slave_select_in;
  // New bit enters at the top: the first bit ends up in bit 0.
  assign nxt_sr = {mosi_in, sr_ff[31:1]};

  // Bit counter and shifter; data sampled on the rising (trailing) edge
  // of the active-low clock with phase set.
  always_ff @(posedge serial_clock_in or negedge sel_rst_n) begin
    if (!sel_rst_n) begin
      bit_cnt_ff <= 5'h00;
      sr_ff <= 32'h00000000;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
      sr_ff <= nxt_sr;
    end
  end

  // Word hand-off: the word stays stable for 32 link clocks after the
  // toggle, far longer than the system side needs to pick it up.
  always_ff @(posedge serial_clock_in or negedge reset_n) begin
    if (!reset_n) begin
      word_ff <= 32'h00000000;
      word_tgl_ff <= 1'b0;
    end else if (bit_cnt_ff == `SBL_LAST_BIT && !slave_select_in) begin
      word_ff <= nxt_sr;
      word_tgl_ff <= ~word_tgl_ff;
    end
  end
endmodule // sbl_link

// File: hw/sbl_top.sv
// Boot-time serial receive port: slave and master boot sequencing and DMA writes.
`timescale 1ns/100ps
`include "sbl_defs.svh"
module sbl_top (
  // System clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Boot configuration pins.
  input wire logic [1:0] boot_cfg_in,
  // Serial pins: link clock and select in slave role, data both ways.
  input wire logic serial_clock_in,
  input wire logic slave_select_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  // Kernel signals that it has loaded the whole program.
  input wire logic kernel_done_in,
  // Serial pins driven in master role.
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic flag0_select_out,
  output logic flag0_select_oe,
  output logic mosi_out,
  output logic mosi_oe,
  output logic miso_out,
  output logic miso_oe,
  // Internal memory write port.
  output logic mem_wr,
  output logic [8:0] mem_addr,
  output logic [31:0] mem_data,
  // Status.
  output sbl_pkg::sbl_mode_e boot_mode,
  output logic boot_busy,
  output logic boot_done,
  output logic [8:0] dma_left,
  // Port configuration as set for boot.
  output logic port_enable_bit,
  output logic master_select_bit,
  output logic msb_first_bit,
  output logic [1:0] word_length_field,
  output logic data_out_disable_bit,
  output logic send_zero_bit,
  output logic receive_dma_enable_bit,
  output logic clock_polarity_bit,
  output logic clock_phase_bit
);
  import sbl_pkg::*;

  localparam logic [31:0] CMD_W = `SBL_CMD_WORD; // Read command, LSB first.
  localparam logic [2:0] HALF_M1 = 3'(`SBL_SCLK_HALF_CYC - 1); // Divider end.

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [1:0] cfg_s; // Synchronised configuration pins.
  logic [1:0] cap_cnt_ff; // Cycles since reset release, until capture.
  logic cfg_done_ff; // Mode has been captured.
  sbl_mode_e mode_ff; // Captured boot mode.
  sbl_state_e state_ff; // Boot sequencer state.
  sbl_state_e nxt_state; // Next sequencer state.
  logic [2:0] div_ff; // Serial clock divider.
  logic sclk_ff; // Serial clock driven in master role.
  logic [4:0] bit_cnt_ff; // Master bit position within the word.
  logic [31:0] rx_sr_ff; // Master receive shift register.
  logic miso_s; // Synchronised master data in.
  logic [31:0] link_word; // Word from the slave-mode shifter.
  logic link_tgl; // Word event toggle from the link domain.
  logic tgl_s; // Synchronised toggle.
  logic tgl_d_ff; // Previous synchronised toggle.
  logic slave_word; // A slave word has arrived.
  logic tick; // Divider end of half period.
  logic rise_ev; // Master clock rises: sample point.
  logic fall_ev; // Master clock falls: start of next bit.
  logic word_end; // Master takes the last bit of a word.
  logic [31:0] rx_next; // Master shift register after this bit.
  logic can_write; // DMA count not yet exhausted.
  logic is_master; // Captured mode is master boot.
  logic is_slave; // Captured mode is slave boot.
  logic mosi_ff, mem_wr_ff, busy_ff, done_ff;
  logic [8:0] mem_addr_ff, dma_left_ff;
  logic [31:0] mem_data_ff;

  // ---------------------------------------------------------------------------
  // Pin synchronisers and link-domain shifter
  // ---------------------------------------------------------------------------
  sbl_sync2 #(.WIDTH(2)) u_cfg_sync (
    .clk(clk), .reset_n(reset_n), .async_in(boot_cfg_in), .sync_out(cfg_s)
  );
  sbl_sync2 #(.WIDTH(1)) u_miso_sync (
    .clk(clk), .reset_n(reset_n), .async_in(miso_in), .sync_out(miso_s)
  );
  sbl_sync2 #(.WIDTH(1)) u_tgl_sync (
    .clk(clk), .reset_n(reset_n), .async_in(link_tgl), .sync_out(tgl_s)
  );
  sbl_link u_link (
    .serial_clock_in(serial_clock_in),
    .reset_n(reset_n),
    .slave_select_in(slave_select_in),
    .mosi_in(mosi_in),
    .word_ff(link_word),
    .word_tgl_ff(link_tgl)
  );

  // ---------------------------------------------------------------------------
  // Boot mode capture
  // ---------------------------------------------------------------------------
  // The pins pass two flops, then are taken once at the third edge after
  // release; later pin changes have no effect until the next reset.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_cnt_ff <= 2'h0;
      cfg_done_ff <= 1'b0;
      mode_ff <= SBL_MODE_NONE;
    end else if (!cfg_done_ff) begin
      cap_cnt_ff <= cap_cnt_ff + 2'h1;
      if (cap_cnt_ff == 2'h2) begin
        cfg_done_ff <= 1'b1;
        mode_ff <= sbl_mode_e'(cfg_s);
      end
    end
  end

  assign is_master = cfg_done_ff && mode_ff == SBL_MODE_MASTER;
  assign is_slave = cfg_done_ff && mode_ff == SBL_MODE_SLAVE;

  // ---------------------------------------------------------------------------
  // Master serial clock and event decode
  // ---------------------------------------------------------------------------
  assign tick = div_ff == HALF_M1;
  assign rise_ev = tick && !sclk_ff;
  assign fall_ev = tick && sclk_ff;
  assign word_end = rise_ev && bit_cnt_ff == `SBL_LAST_BIT;
  assign rx_next = {miso_s, rx_sr_ff[31:1]};
  assign can_write = dma_left_ff != 9'h000;
  assign slave_word = tgl_s ^ tgl_d_ff;

  // ---------------------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------------------
  // Master: command word, then data until the kernel reports done and the DMA count is spent.
  // Slave: data as soon as the mode is known, until the DMA count is spent.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SBL_ST_IDLE: begin
        if (is_master) begin
          nxt_state = SBL_ST_CMD;
        end else if (is_slave) begin
          nxt_state = SBL_ST_DATA;
        end
      end
      SBL_ST_CMD: begin
        if (word_end) begin
          nxt_state = SBL_ST_DATA;
        end
      end
      SBL_ST_DATA: begin
        if (is_master && word_end && kernel_done_in && dma_left_ff <= 9'h001) begin
          nxt_state = SBL_ST_DONE;
        end else if (is_slave && slave_word && dma_left_ff == 9'h001) begin
          nxt_state = SBL_ST_DONE;
        end
      end
      default: begin
        nxt_state = SBL_ST_DONE;
      end
    endcase
  end

  // Divider and master clock; the clock idles high and only runs in a
  // master frame, so the slave sees edges only while selected.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_ff <= 3'h0;
      sclk_ff <= 1'b1;
    end else if (is_master && (state_ff == SBL_ST_CMD || state_ff == SBL_ST_DATA)) begin
      div_ff <= tick ? 3'h0 : div_ff + 3'h1;
      sclk_ff <= tick ? ~sclk_ff : sclk_ff;
    end else begin
      div_ff <= 3'h0;
      sclk_ff <= 1'b1;
    end
  end

  // State, bit count and master shift path. One command word goes out LSB
  // first while the word coming back is shifted but never written.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= SBL_ST_IDLE;
      bit_cnt_ff <= 5'h00;
      rx_sr_ff <= 32'h00000000;
      mosi_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == SBL_ST_IDLE && is_master) begin
        mosi_ff <= CMD_W[0];
      end else if (rise_ev) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
        rx_sr_ff <= rx_next;
      end else if (fall_ev) begin
        // Data leads each bit; after the command the data line rests low.
        mosi_ff <= (state_ff == SBL_ST_CMD) ? CMD_W[bit_cnt_ff] : 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // DMA write port
  // ---------------------------------------------------------------------------
  // Writes land only from the data phase and stop when the count is spent;
  // the command-phase word never reaches memory.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tgl_d_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      mem_addr_ff <= 9'h000;
      mem_data_ff <= 32'h00000000;
      dma_left_ff <= `SBL_DMA_WORDS;
    end else begin
      tgl_d_ff <= tgl_s;
      mem_wr_ff <= 1'b0;
      if (state_ff == SBL_ST_DATA && can_write &&
          ((is_master && word_end) || (is_slave && slave_word))) begin
        mem_wr_ff <= 1'b1;
        mem_data_ff <= is_master ? rx_next : link_word;
        mem_addr_ff <= `SBL_DMA_WORDS - dma_left_ff;
        dma_left_ff <= dma_left_ff - 9'h001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Status, configuration and pin drive
  // ---------------------------------------------------------------------------
  // Configuration bits follow the captured mode; slave mode keeps its data
  // output disabled for the whole boot.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      port_enable_bit <= 1'b0;
      master_select_bit <= 1'b0;
      msb_first_bit <= 1'b0;
      word_length_field <= 2'h0;
      data_out_disable_bit <= 1'b0;
      send_zero_bit <= 1'b0;
      receive_dma_enable_bit <= 1'b0;
      clock_polarity_bit <= 1'b0;
      clock_phase_bit <= 1'b0;
    end else begin
      busy_ff <= state_ff == SBL_ST_CMD || state_ff == SBL_ST_DATA;
      done_ff <= state_ff == SBL_ST_DONE;
      port_enable_bit <= is_master || is_slave;
      master_select_bit <= is_master;
      msb_first_bit <= 1'b0;
      word_length_field <= (is_master || is_slave) ? `SBL_WL_32 : 2'h0;
      data_out_disable_bit <= is_slave;
      send_zero_bit <= 1'b0;
      receive_dma_enable_bit <= is_master || is_slave;
      clock_polarity_bit <= is_master || is_slave;
      clock_phase_bit <= is_master || is_slave;
    end
  end

  // Pin drivers are registered; the select stays low through the frame.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_clock_out <= 1'b1;
      serial_clock_oe <= 1'b0;
      flag0_select_out <= 1'b1;
      flag0_select_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      serial_clock_out <= sclk_ff;
      serial_clock_oe <= is_master;
      flag0_select_out <= !(is_master && busy_ff);
      flag0_select_oe <= is_master;
      mosi_out <= mosi_ff;
      mosi_oe <= is_master;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end
  end

  assign mem_wr = mem_wr_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_data = mem_data_ff;
  assign boot_mode = mode_ff;
  assign boot_busy = busy_ff;
  assign boot_done = done_ff;
  assign dma_left = dma_left_ff;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  fixed_len_a: assert property (port_enable_bit |-> word_length_field == 2'h2)
    else $error("word length field is not 32-bit");
  dma_count_a: assert property (mem_wr_ff |-> mem_addr_ff + dma_left_ff == 9'h17F)
    else $error("DMA address and count disagree");
  slave_cfg_a: assert property (is_slave ##1 1'b1 |-> port_enable_bit && !master_select_bit
    && !msb_first_bit && receive_dma_enable_bit && !send_zero_bit)
    else $error("slave boot configuration wrong");
  slave_out_a: assert property (is_slave |-> !miso_oe && !mosi_oe && !serial_clock_oe)
    else $error("pin driven during slave boot");
  sel_low_a: assert property ($rose(busy_ff) && is_master |=> !flag0_select_out)
    else $error("flag select not low in master frame");
  cmd_bits_a: assert property ($rose(sclk_ff) && state_ff == SBL_ST_CMD
    |-> mosi_ff == CMD_W[$past(bit_cnt_ff)])
    else $error("command bit wrong");
  cmd_discard_a: assert property (state_ff == SBL_ST_CMD |=> !mem_wr_ff)
    else $error("command-phase word written");
  data_start_a: assert property (state_ff == SBL_ST_CMD && nxt_state == SBL_ST_DATA
    |-> bit_cnt_ff == 5'h1F ##1 bit_cnt_ff == 5'h00)
    else $error("data phase not at cycle 32");
  mode_hold_a: assert property (cfg_done_ff |=> $stable(mode_ff))
    else $error("boot mode changed after capture");

  master_done_c: cover property (is_master && $rose(done_ff));
  slave_done_c: cover property (is_slave && $rose(done_ff));
  slave_word_c: cover property (is_slave && mem_wr_ff);
endmodule // sbl_top

// File: test/sbl_host_model.sv
// Far-side model: SPI host master in slave boot, slave host in master boot.
`timescale 1ns/100ps
module sbl_host_model (
  // Pins that the model drives toward the device.
  output logic serial_clock_in,
  output logic slave_select_in,
  output logic mosi_in,
  output logic miso_in,
  // Pins that the device drives in master boot.
  input wire logic serial_clock_out,
  input wire logic flag0_select_out,
  input wire logic mosi_out
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [31:0] miso_q[$]; // Words that the slave host returns in master boot.
  logic [31:0] miso_word; // Word now being shifted out.
  logic [31:0] cmd_word; // Command bits seen, first wire bit in bit 0.
  int cmd_cnt; // Rising clock edges counted in this master frame, up to 32.
  int miso_bit; // Next bit of miso_word.

  // Idle levels: clock stands high outside frames, select released.
  initial begin
    serial_clock_in = 1'b1;
    slave_select_in = 1'b1;
    mosi_in = 1'b0;
    miso_in = 1'b0;
    miso_word = 32'h0;
    cmd_word = 32'h0;
    cmd_cnt = 0;
    miso_bit = 0;
  end

  // ---------------------------------------------------------------------------
  // Slave boot: the model is the host master
  // ---------------------------------------------------------------------------
  // Select falls from high to start a frame; odd delay keeps phase unrelated.
  task automatic select_fall();
    #17.3 slave_select_in = 1'b0;
  endtask

  // Releasing select also releases data, so it shows the inverse level.
  task automatic select_rise();
    #100 slave_select_in = 1'b1;
    mosi_in = ~mosi_in;
  endtask

  // Bits go out LSB first with no gap; data changes at the falling edge.
  task automatic slave_bits(input logic [31:0] word, input int nbits);
    for (int i = 0; i < nbits; i++) begin
      #62.5 serial_clock_in = 1'b0;
      mosi_in = word[i];
      #62.5 serial_clock_in = 1'b1;
    end
  endtask

  // ---------------------------------------------------------------------------
  // Master boot: the model is a slave host that sends from the first bit
  // ---------------------------------------------------------------------------
  // A new frame restarts both bit counters.
  always @(negedge flag0_select_out) begin
    cmd_cnt = 0;
    miso_bit = 0;
  end

  // Capture the first 32 command bits at the device's sampling edge.
  always @(posedge serial_clock_out) begin
    if (flag0_select_out === 1'b0 && cmd_cnt < 32) begin
      cmd_word[cmd_cnt] = mosi_out;
      cmd_cnt = cmd_cnt + 1;
    end
  end

  // Drive the next bit at each falling edge; filler word is queued first.
  // A bit-reversed image in an MSB-first memory puts these same bits out.
  always @(negedge serial_clock_out) begin
    if (flag0_select_out === 1'b0) begin
      if (miso_bit == 0) begin
        miso_word = (miso_q.size() > 0) ? miso_q.pop_front() : ~miso_word;
      end
      miso_in = miso_word[miso_bit];
      miso_bit = (miso_bit + 1) % 32;
    end
  end

  // Out of frame the line is released and no longer holds its last value.
  always @(posedge flag0_select_out) begin
    miso_in = ~miso_in;
  end
endmodule // sbl_host_model

// File: test/sbl_top_tb.sv
// Self-checking testbench of the serial boot loader port.
`timescale 1ns/100ps
`include "sbl_defs.svh"
module sbl_top_tb;
  import sbl_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] boot_cfg_in = 2'h0;
  logic kernel_done_in = 1'b0;
  logic serial_clock_in, slave_select_in, mosi_in, miso_in;
  logic serial_clock_out, serial_clock_oe, flag0_select_out, flag0_select_oe;
  logic mosi_out, mosi_oe, miso_out, miso_oe, mem_wr, boot_busy, boot_done;
  logic [8:0] mem_addr, dma_left;
  logic [31:0] mem_data;
  sbl_mode_e boot_mode;
  logic port_enable_bit, master_select_bit, msb_first_bit, data_out_disable_bit;
  logic send_zero_bit, receive_dma_enable_bit, clock_polarity_bit, clock_phase_bit;
  logic [1:0] word_length_field;
  logic [11:0] cfg_seen; // Port setup bits, then miso_oe and serial_clock_oe.
  logic [40:0] exp_q[$]; // Expected writes as {address, data}.
  logic [40:0] exp_w;
  logic [31:0] w;
  int err_count = 0;
  int samples_checked = 0;

  assign cfg_seen = {port_enable_bit, master_select_bit, msb_first_bit, word_length_field,
    data_out_disable_bit, send_zero_bit, receive_dma_enable_bit, clock_polarity_bit,
    clock_phase_bit, miso_oe, serial_clock_oe};

  // 20 MHz system clock.
  always #25 clk = ~clk;

  sbl_top dut (.clk(clk), .reset_n(reset_n), .boot_cfg_in(boot_cfg_in),
    .serial_clock_in(serial_clock_in), .slave_select_in(slave_select_in),
    .mosi_in(mosi_in), .miso_in(miso_in), .kernel_done_in(kernel_done_in),
    .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
    .flag0_select_out(flag0_select_out), .flag0_select_oe(flag0_select_oe),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_data(mem_data), .boot_mode(boot_mode),
    .boot_busy(boot_busy), .boot_done(boot_done), .dma_left(dma_left),
    .port_enable_bit(port_enable_bit), .master_select_bit(master_select_bit),
    .msb_first_bit(msb_first_bit), .word_length_field(word_length_field),
    .data_out_disable_bit(data_out_disable_bit), .send_zero_bit(send_zero_bit),
    .receive_dma_enable_bit(receive_dma_enable_bit),
    .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit));

  sbl_host_model host (.serial_clock_in(serial_clock_in), .slave_select_in(slave_select_in),
    .mosi_in(mosi_in), .miso_in(miso_in), .serial_clock_out(serial_clock_out),
    .flag0_select_out(flag0_select_out), .mosi_out(mosi_out));

  // ---------------------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------------------
  // One compare for every kind of value; four-state so X never matches.
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The write pulse stands one cycle, so it is read mid-cycle where settled.
  always @(negedge clk) begin
    if (mem_wr === 1'b1) begin
      if (exp_q.size() == 0) begin
        check_val("unexpected write", 32'h0, 32'h1);
      end else begin
        exp_w = exp_q.pop_front();
        check_val("mem_addr", {23'h0, exp_w[40:32]}, {23'h0, mem_addr});
        check_val("mem_data", exp_w[31:0], mem_data);
      end
    end
  end

  // Reset, pick a boot source and check what was captured from the pins.
  task automatic boot(input logic [1:0] cfg, input logic [11:0] exp_cfg);
    @(posedge clk);
    #5 reset_n = 1'b0;
    boot_cfg_in = cfg;
    repeat (5) @(posedge clk);
    #5 reset_n = 1'b1;
    repeat (6) @(posedge clk);
    #5 check_val("boot_mode", {30'h0, cfg}, {30'h0, boot_mode});
    check_val("setup bits", {20'h0, exp_cfg}, {20'h0, cfg_seen});
    check_val("dma_left", 32'h180, {23'h0, dma_left});
  endtask

  // Wait, bounded, until every expected write has been seen.
  task automatic drain(input int limit);
    for (int n = 0; n < limit && exp_q.size() > 0; n++) @(posedge clk);
    repeat (20) @(posedge clk);
    #5 check_val("writes left", 32'h0, exp_q.size());
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog: the whole run is about 35000 cycles.
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    end_of_test();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    w = $urandom(32'hD227);
    // Parallel and no-boot sources leave the port idle.
    boot(2'h2, 12'h000);
    boot(2'h3, 12'h000);
    // Slave boot: enabled, slave, LSB first, length 10, out off, DMA, clock low.
    boot(2'h0, 12'h95C);
    // A partial word cut by select is lost and counting restarts.
    host.select_fall();
    host.slave_bits($urandom(), 20);
    host.select_rise();
    // 385 words back to back: only the DMA count of 384 is written.
    host.select_fall();
    for (int i = 0; i < 385; i++) begin
      w = $urandom();
      if (i < 384) exp_q.push_back({9'(i), w});
      host.slave_bits(w, 32);
    end
    host.select_rise();
    drain(600);
    check_val("dma_left end", 32'h0, {23'h0, dma_left});
    check_val("boot_done", 32'h1, {31'h0, boot_done});
    check_val("slave data out", 32'h0, {31'h0, miso_out});
    // Master boot against a slave host, a PROM and a flash: the first word is
    // lost in the command phase, then three kernel words land.
    for (int k = 0; k < 3; k++) begin
      w = $urandom();
      // Host filler word; PROM filler byte after 24 idle bits; flash idle bits.
      w = (k == 0) ? 32'hA5000000 : (k == 1) ? {8'hA5, w[23:0]} : w;
      host.miso_q.push_back(w);
      for (int i = 0; i < 3; i++) begin
        w = $urandom();
        host.miso_q.push_back(w);
        exp_q.push_back({9'(i), w});
      end
      boot(2'h1, 12'hD1D);
      drain(1300);
      // Read opcode 03 and zero address on the wire give C0 in LSB-first order.
      check_val("command word", {24'h000000, 8'hC0}, host.cmd_word);
      check_val("frame select", 32'h0, {31'h0, flag0_select_out});
      check_val("select enable", 32'h1, {31'h0, flag0_select_oe});
      check_val("master busy", 32'h1, {31'h0, boot_busy});
      check_val("data enable", 32'h1, {31'h0, mosi_oe});
      // The last run has the kernel report done early: the count is not spent,
      // so clocking must go on.
      kernel_done_in = (k == 1);
    end
    end_of_test();
  end
endmodule // sbl_top_tb
